/* File: rtl/chri_host_regs.v */
// Purpose: host register bank, indirect mode control and stream queue
// Assumes: host strobes are one-cycle pulses synchronous to core_clk
// Notes: core side pushes or pops the queue through plain ports
`timescale 1ns/1ns
`default_nettype none
`include "chri_regs.vh"
module chri_host_regs #(
  parameter DEPTH_LOG = 9
) (
  input wire core_clk,
  input wire srst,
  input wire [3:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [3:0] host_be,
  input wire [31:0] host_wdata,
  output reg [31:0] host_rdata,
  output reg host_interrupt_pin,
  input wire format_error_in,
  input wire stats_ready_in,
  input wire last_word_in,
  input wire memory_fault_in,
  input wire field_done_in,
  input wire core_push,
  input wire [31:0] core_push_data,
  input wire core_pop,
  output reg [31:0] core_pop_data,
  output reg [15:0] indexed_write_data,
  output reg [15:0] indexed_write_index,
  output reg indexed_write_strobe,
  input wire [15:0] indexed_read_data,
  output reg stats_ready_pin,
  output reg last_word_pin,
  output reg service_request_pin,
  output reg queue_error_pin,
  output reg queue_stop_pin,
  output reg [3:0] video_format_select,
  output reg clock_out_halve,
  output reg master_timing,
  output reg lines_625,
  output reg encode_mode,
  output reg square_pixel_enable,
  output reg colour_coding_select,
  output reg dsp_bin_width,
  output reg soft_reset_bit,
  output reg processing_halted,
  output reg hsync_polarity,
  output reg interrupt_polarity
);
  localparam DEPTH = 1 << DEPTH_LOG;
  localparam ST_RUN = 2'b01;
  localparam ST_HALT = 2'b10;

  // ****************************************
  // register state
  // ****************************************
  reg [15:0] index_value;
  reg [15:0] mode_reg;
  reg [7:0] fifo_ctl;
  reg [7:0] data_low;
  reg [6:0] irq_enable;
  reg [6:0] sticky;
  reg [6:0] cond_prev;
  reg [1:0] state;
  reg [DEPTH_LOG:0] level;
  reg [DEPTH_LOG-1:0] wr_ptr;
  reg [DEPTH_LOG-1:0] rd_ptr;
  reg [31:0] stream_acc;

  // ****************************************
  // address decode
  // ****************************************
  wire sel_index = (host_addr == `CHRI_OFF_INDEX);
  wire sel_data = (host_addr == `CHRI_OFF_DATA);
  wire sel_stream = (host_addr == `CHRI_OFF_STREAM);
  wire sel_irq = (host_addr == `CHRI_OFF_IRQ);


  // ****************************************
  // lane helpers
  // ****************************************
  // final byte lane of a narrow or full access
  function top_lane;
    input [3:0] be;
    input hi;
    begin
      top_lane = hi ? be[3] : be[1];
    end
  endfunction

  wire data_acc = sel_data && (host_wr || host_rd);
  wire data_done = data_acc && top_lane(host_be, 1'b0);
  wire stream_wr_done = sel_stream && host_wr && top_lane(host_be, 1'b1);
  wire stream_rd_done = sel_stream && host_rd && top_lane(host_be, 1'b1);

  // ****************************************
  // queue accounting
  // ****************************************
  wire enc = mode_reg[`CHRI_BIT_ENCODE];
  wire q_full = (level == DEPTH[DEPTH_LOG:0]);
  wire q_empty = (level == {(DEPTH_LOG+1){1'b0}});
  wire push_req = enc ? core_push : stream_wr_done;
  wire pop_req = enc ? stream_rd_done : core_pop;
  wire do_push = push_req && !q_full;
  wire do_pop = pop_req && !q_empty;
  wire [31:0] push_data;
  wire [31:0] mem_rd;
  wire [DEPTH_LOG-1:0] next_rd_ptr = rd_ptr + {{(DEPTH_LOG-1){1'b0}}, do_pop};

  chri_fifo_mem #(.WIDTH(32), .DEPTH_LOG(DEPTH_LOG)) u_mem (
    .core_clk(core_clk),
    .wr_en(do_push),
    .wr_addr(wr_ptr),
    .wr_data(push_data),
    .rd_addr(next_rd_ptr),
    .rd_data(mem_rd)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      assign push_data[g*8+7:g*8] = enc ? core_push_data[g*8+7:g*8] :
        (host_be[g] ? host_wdata[g*8+7:g*8] : stream_acc[g*8+7:g*8]);
    end
  endgenerate

  wire [DEPTH_LOG:0] enc_thr = {{(DEPTH_LOG-3){1'b0}}, fifo_ctl[3:0]} << `CHRI_LEVEL_STEP;
  wire [DEPTH_LOG:0] dec_thr = {{(DEPTH_LOG-3){1'b0}}, fifo_ctl[7:4]} << `CHRI_LEVEL_STEP;
  wire [DEPTH_LOG:0] free_cnt = DEPTH[DEPTH_LOG:0] - level;


  // ****************************************
  // status conditions
  // ****************************************
  // nearly full or empty
  wire srq_cond = enc ? (fifo_ctl[3:0] != 4'h0 && level >= enc_thr) :
    (fifo_ctl[7:4] != 4'h0 && free_cnt >= dec_thr);
  wire err_cond = enc ? (core_push && q_full) :
    ((core_pop && q_empty) || (stream_wr_done && q_full));
  // stop with 32 spare in decode
  wire stop_cond = enc ? q_empty : (free_cnt <= `CHRI_STOP_MARGIN);
  wire [6:0] cond = {memory_fault_in, stop_cond, err_cond, srq_cond,
    last_word_in, stats_ready_in, format_error_in};
  wire [6:0] rise = cond & ~cond_prev;
  wire [6:0] status = {sticky[6:4], srq_cond, sticky[2:0]};
  wire irq_any = |(status & irq_enable);
  wire irq_clear = sel_irq && host_rd;
  wire [6:0] next_sticky = ((irq_clear ? 7'h00 : sticky) | rise) & `CHRI_STAT_MASK &
    `CHRI_STICKY_MASK;


  // ****************************************
  // clocked state
  // ****************************************
  always @(posedge core_clk) begin
    indexed_write_strobe <= 1'b0;
    if (srst) begin
      index_value <= 16'h0000;
      mode_reg <= `CHRI_MODE_RESET;
      fifo_ctl <= `CHRI_FIFOCTL_RESET;
      data_low <= 8'h00;
      irq_enable <= 7'h00;
      sticky <= 7'h00;
      cond_prev <= 7'h00;
      level <= {(DEPTH_LOG+1){1'b0}};
      wr_ptr <= {DEPTH_LOG{1'b0}};
      rd_ptr <= {DEPTH_LOG{1'b0}};
      stream_acc <= 32'h00000000;
      indexed_write_data <= 16'h0000;
      indexed_write_index <= 16'h0000;
      host_rdata <= 32'h00000000;
    end else begin
      cond_prev <= cond;
      sticky <= next_sticky;
      if (sel_index && host_wr) begin
        if (host_be[0]) begin
          index_value[7:0] <= host_wdata[7:0];
        end
        if (host_be[1]) begin
          index_value[15:8] <= host_wdata[15:8];
        end
      end else if (data_done) begin
        index_value <= index_value + 16'h0001;
      end
      if (sel_data && host_wr && host_be[0]) begin
        data_low <= host_wdata[7:0];
      end
      if (sel_data && host_wr && host_be[1]) begin
        indexed_write_index <= index_value;
        indexed_write_data <= {host_wdata[15:8], host_be[0] ? host_wdata[7:0] : data_low};
        indexed_write_strobe <= 1'b1;
        if (index_value == `CHRI_IDX_MODE) begin
          mode_reg <= {host_wdata[15:8],
            host_be[0] ? host_wdata[7:0] : data_low} & `CHRI_MODE_MASK;
        end else if (index_value == `CHRI_IDX_FIFOCTL) begin
          fifo_ctl <= host_be[0] ? host_wdata[7:0] : data_low;
        end
      end
      if (sel_irq && host_wr && host_be[1]) begin
        irq_enable <= host_wdata[14:8];
      end
      if (sel_stream && host_wr && !enc) begin
        stream_acc <= push_data;
      end
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(DEPTH_LOG-1){1'b0}}, 1'b1};
      end
      rd_ptr <= next_rd_ptr;
      level <= level + {{DEPTH_LOG{1'b0}}, do_push} - {{DEPTH_LOG{1'b0}}, do_pop};
      // read data, reserved bits zero
      if (host_rd) begin
        if (sel_data) begin
          host_rdata <= {16'h0000, indexed_read_data};
        end else if (sel_stream) begin
          host_rdata <= enc ? mem_rd : 32'h00000000;
        end else if (sel_irq) begin
          host_rdata <= {16'h0000, 1'b0, irq_enable, 1'b0, status};
        end else begin
          host_rdata <= 32'h00000000;
        end
      end
    end
  end

  // ****************************************
  // pins and halt state
  // ****************************************
  always @(posedge core_clk) begin
    if (srst) begin
      host_interrupt_pin <= 1'b1;
      core_pop_data <= 32'h00000000;
      stats_ready_pin <= 1'b0;
      last_word_pin <= 1'b0;
      service_request_pin <= 1'b0;
      queue_error_pin <= 1'b0;
      queue_stop_pin <= 1'b0;
      state <= ST_HALT;
      processing_halted <= 1'b1;
    end else begin
      host_interrupt_pin <= mode_reg[`CHRI_BIT_IRQPOL] ? irq_any : ~irq_any;
      core_pop_data <= mem_rd;
      stats_ready_pin <= stats_ready_in;
      last_word_pin <= last_word_in;
      service_request_pin <= srq_cond;
      queue_error_pin <= err_cond;
      queue_stop_pin <= stop_cond;
      case (state)
        ST_RUN: begin
          if (mode_reg[`CHRI_BIT_SWR] && (!enc || field_done_in)) begin
            state <= ST_HALT;
            processing_halted <= 1'b1;
          end
        end
        ST_HALT: begin
          if (!mode_reg[`CHRI_BIT_SWR]) begin
            state <= ST_RUN;
            processing_halted <= 1'b0;
          end
        end
        default: begin
          state <= ST_HALT;
          processing_halted <= 1'b1;
        end
      endcase
    end
  end


  // ****************************************
  // mode field copies
  // ****************************************
  // mode fields
  always @(posedge core_clk) begin
    if (srst) begin
      video_format_select <= `CHRI_FMT_COMP;
      clock_out_halve <= 1'b0;
      master_timing <= 1'b0;
      lines_625 <= 1'b0;
      encode_mode <= 1'b1;
      square_pixel_enable <= 1'b1;
      colour_coding_select <= 1'b0;
      dsp_bin_width <= 1'b0;
      soft_reset_bit <= 1'b1;
      hsync_polarity <= 1'b0;
      interrupt_polarity <= 1'b0;
    end else begin
      video_format_select <= mode_reg[3:0];
      clock_out_halve <= mode_reg[`CHRI_BIT_HALVE];
      master_timing <= mode_reg[`CHRI_BIT_MASTER];
      lines_625 <= mode_reg[`CHRI_BIT_625];
      encode_mode <= enc;
      square_pixel_enable <= mode_reg[`CHRI_BIT_SQUARE];
      colour_coding_select <= mode_reg[`CHRI_BIT_COLOUR];
      dsp_bin_width <= mode_reg[`CHRI_BIT_DSP];
      soft_reset_bit <= mode_reg[`CHRI_BIT_SWR];
      hsync_polarity <= mode_reg[`CHRI_BIT_HSPOL];
      interrupt_polarity <= mode_reg[`CHRI_BIT_IRQPOL];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/chri_regs.vh */
// Purpose: constants for the codec host register interface
// Assumes: byte offsets on a 4-bit host address, 32-bit data
// Notes: included by the register block only, not by the storage array
`ifndef CHRI_REGS_VH
`define CHRI_REGS_VH
`define CHRI_OFF_INDEX 4'h0
`define CHRI_OFF_DATA 4'h4
`define CHRI_OFF_STREAM 4'h8
`define CHRI_OFF_IRQ 4'hc
`define CHRI_IDX_MODE 16'h0000
`define CHRI_IDX_FIFOCTL 16'h0001
`define CHRI_MODE_RESET 16'h0983
`define CHRI_FIFOCTL_RESET 8'h88
`define CHRI_MODE_MASK 16'h3fff
`define CHRI_STAT_MASK 7'h7f
`define CHRI_STICKY_MASK 7'h77
`define CHRI_FMT_CCIR 4'h0
`define CHRI_FMT_MUX 4'h2
`define CHRI_FMT_COMP 4'h3
`define CHRI_FMT_GREY 4'h8
`define CHRI_BIT_HALVE 4
`define CHRI_BIT_MASTER 5
`define CHRI_BIT_625 6
`define CHRI_BIT_ENCODE 7
`define CHRI_BIT_SQUARE 8
`define CHRI_BIT_COLOUR 9
`define CHRI_BIT_DSP 10
`define CHRI_BIT_SWR 11
`define CHRI_BIT_HSPOL 12
`define CHRI_BIT_IRQPOL 13
`define CHRI_LEVEL_STEP 5
`define CHRI_STOP_MARGIN 10'd32
`endif

/* File: rtl/chri_fifo_mem.v */
// Purpose: storage array for the compressed-data queue
// Assumes: one write and one registered read per cycle
// Notes: read data is held in a flip-flop
`timescale 1ns/1ns
`default_nettype none
module chri_fifo_mem #(
  parameter WIDTH = 32,
  parameter DEPTH_LOG = 9
) (
  input wire core_clk,
  input wire wr_en,
  input wire [DEPTH_LOG-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [DEPTH_LOG-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG)-1];
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* File: test/chri_host_regs_properties.sv */
// Purpose: port checks for the host register block
// Assumes: one clock, synchronous active high reset
// Notes: bound into every instance of the block
`timescale 1ns/1ns
`default_nettype none
module chri_host_regs_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] host_be,
  input wire logic [31:0] host_rdata,
  input wire logic host_interrupt_pin,
  input wire logic stats_ready_in,
  input wire logic stats_ready_pin,
  input wire logic service_request_pin,
  input wire logic indexed_write_strobe,
  input wire logic [15:0] indexed_write_index,
  input wire logic [15:0] indexed_write_data,
  input wire logic [3:0] video_format_select,
  input wire logic clock_out_halve,
  input wire logic master_timing,
  input wire logic lines_625,
  input wire logic encode_mode,
  input wire logic square_pixel_enable,
  input wire logic colour_coding_select,
  input wire logic dsp_bin_width,
  input wire logic soft_reset_bit,
  input wire logic processing_halted,
  input wire logic hsync_polarity,
  input wire logic interrupt_polarity
);
  logic [15:0] last_idx;
  logic chain;
  logic [13:0] mode_out;
  assign mode_out = {interrupt_polarity, hsync_polarity, soft_reset_bit, dsp_bin_width,
    colour_coding_select, square_pixel_enable, encode_mode, lines_625, master_timing,
    clock_out_halve, video_format_select};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****
  // index chain between indirect writes
  // ****
  always @(posedge core_clk) begin
    if (srst || (host_wr && host_addr == 4'h0) || (host_rd && host_addr == 4'h4)) begin
      chain <= 1'b0;
    end else if (indexed_write_strobe) begin
      chain <= 1'b1;
    end
    if (indexed_write_strobe) begin
      last_idx <= indexed_write_index;
    end
  end
  a_rdata_hold_steady: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved without a read");
  a_index_step_up: assert property (indexed_write_strobe && chain |->
    indexed_write_index == last_idx + 16'h1) else $error("index did not step");
  a_write_strobe_out: assert property (host_wr && host_addr == 4'h4 && host_be[1]
    |=> indexed_write_strobe) else $error("indirect write not passed on");
  a_byte_zero_wait: assert property (host_wr && host_addr == 4'h4 && host_be == 4'h1
    |=> !indexed_write_strobe) else $error("byte 0 completed a write");
  a_mode_copy_out: assert property (indexed_write_strobe && indexed_write_index == 16'h0
    |=> {2'b00, mode_out} == ($past(indexed_write_data) & 16'h3fff)) else $error("mode copy");
  a_halt_release_next: assert property ($fell(soft_reset_bit) |=> !processing_halted)
    else $error("still halted after soft reset cleared");
  a_decode_halt_now: assert property ($rose(soft_reset_bit) && !encode_mode
    |-> ##[0:2] processing_halted) else $error("decode did not halt");
  a_reset_state_out: assert property ($fell(srst) |-> soft_reset_bit && processing_halted
    && encode_mode && host_interrupt_pin && !service_request_pin) else $error("reset state");
  a_stats_pin_follow: assert property (stats_ready_pin == $past(stats_ready_in))
    else $error("stats pin does not follow");
endmodule
bind chri_host_regs chri_host_regs_properties u_chri_host_regs_properties (.*);
`default_nettype wire

/* File: test/chri_host_model.sv */
// Purpose: host processor model on the register bus
// Assumes: strobe taken on rising edge, read data valid next cycle
// Notes: released strobes go low, address, enable and data lines carry inverted values
`timescale 1ns/1ns
`default_nettype none
module chri_host_model (
  input wire logic core_clk,
  output logic [3:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [3:0] host_be,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata
);
  initial begin
    {host_wr, host_rd, host_addr, host_be} = 10'h0;
    host_wdata = 32'h0;
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
    @(negedge core_clk);
    {host_wr, host_rd, host_addr, host_be} = {w, ~w, a, be};
    host_wdata = d;
    @(negedge core_clk);
    q = host_rdata;
    {host_wr, host_rd, host_addr, host_be} = {2'b00, ~a, ~be};
    host_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: test/chri_host_regs_tb_top.sv */
// Purpose: self-checking bench for the host register block
// Assumes: queue shortened to 64 words
// Notes: random values from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module chri_host_regs_tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] host_addr, host_be, cond, video_format_select, be;
  logic host_wr, host_rd, host_interrupt_pin, field_done_in, core_push, core_pop;
  logic [31:0] host_wdata, host_rdata, core_push_data, core_pop_data, q, got;
  logic [15:0] indexed_write_data, indexed_write_index, indexed_read_data, m, base;
  logic indexed_write_strobe, stats_ready_pin, last_word_pin, service_request_pin;
  logic queue_error_pin, queue_stop_pin, clock_out_halve, master_timing, lines_625;
  logic encode_mode, square_pixel_enable, colour_coding_select, dsp_bin_width;
  logic soft_reset_bit, processing_halted, hsync_polarity, interrupt_polarity;
  wire format_error_in, stats_ready_in, last_word_in, memory_fault_in;
  wire [13:0] mo = {interrupt_polarity, hsync_polarity, soft_reset_bit, dsp_bin_width,
    colour_coding_select, square_pixel_enable, encode_mode, lines_625, master_timing,
    clock_out_halve, video_format_select};
  logic [3:0] fmts [4] = '{4'h0, 4'h2, 4'h3, 4'h8};
  logic [31:0] flag [4] = '{32'h01, 32'h02, 32'h04, 32'h40};
  logic [31:0] words [$];
  int errors = 0;
  int checks = 0;
  int n;
  assign {memory_fault_in, last_word_in, stats_ready_in, format_error_in} = cond;
  chri_host_regs #(.DEPTH_LOG(6)) u_chri_host_regs (.*);
  chri_host_model u_chri_host_model (.*);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ****
  // shared tasks
  // ****
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
    u_chri_host_model.acc(1'b1, a, b, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] b);
    u_chri_host_model.acc(1'b0, a, b, 32'h0, q);
  endtask
  task automatic mode(input logic [15:0] v);
    wr(4'h0, 4'h3, 32'h0);
    wr(4'h4, 4'h3, {16'h0, v | 16'h0800});
    wr(4'h0, 4'h3, 32'h0);
    wr(4'h4, 4'h3, {16'h0, v});
    repeat (2) @(negedge core_clk);
  endtask
  function automatic logic [31:0] lanes(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  // run needs some three hundred and thirty cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {cond, field_done_in, core_push, core_pop} = 7'h0;
    core_push_data = 32'h0;
    indexed_read_data = 16'h0;
    q = $urandom(21896);
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    rd(4'hc, 4'h3);
    cmp(q & 32'hffffffc7, 32'h0);
    rd(4'h2, 4'hf);
    cmp(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = (16'($urandom()) & 16'h37f0) | {12'h0, fmts[i]};
      mode(m);
      cmp({18'h0, mo}, {16'h0, m});
      cmp({31'h0, processing_halted}, 32'h0);
    end
    base = {8'h40, 8'($urandom())};
    wr(4'h0, 4'h3, {16'h0, base});
    for (int k = 0; k < 3; k++) begin
      m = 16'($urandom());
      wr(4'h4, 4'h3, {16'h0, m});
      cmp({15'h0, indexed_write_strobe, indexed_write_data}, {16'h1, m});
      cmp({16'h0, indexed_write_index}, {16'h0, base + 16'(k)});
    end
    wr(4'h4, 4'h1, 32'h000000a5);
    cmp({31'h0, indexed_write_strobe}, 32'h0);
    wr(4'h4, 4'h2, 32'h00003c00);
    cmp({indexed_write_index, indexed_write_data}, {base + 16'h3, 16'h3ca5});
    indexed_read_data = 16'($urandom());
    rd(4'h4, 4'h3);
    cmp(q, {16'h0, indexed_read_data});
    for (int i = 0; i < 4; i++) begin
      cond = 4'h1 << i;
      repeat (3) @(negedge core_clk);
      cmp({31'h0, last_word_pin}, {31'h0, cond[2]});
      cond = 4'h0;
      rd(4'hc, 4'h3);
      cmp(q & 32'h47, flag[i]);
      rd(4'hc, 4'h3);
      cmp(q & 32'h47, 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      mode({2'b00, p[0], 13'h0083});
      for (int e = 0; e < 2; e++) begin
        rd(4'hc, 4'h3);
        wr(4'hc, 4'h3, {23'h0, e[0], 8'h0});
        cond = 4'h1;
        repeat (4) @(negedge core_clk);
        cmp({31'h0, host_interrupt_pin}, {31'h0, p[0] ~^ e[0]});
        cond = 4'h0;
        rd(4'hc, 4'h3);
        cmp(q & 32'h7f47, {23'h0, e[0], 8'h01});
        repeat (3) @(negedge core_clk);
        cmp({31'h0, host_interrupt_pin}, {31'h0, ~p[0]});
      end
    end
    mode(16'h0083);
    wr(4'h0, 4'h3, 32'h1);
    wr(4'h4, 4'h3, 32'h1);
    cmp({31'h0, queue_stop_pin}, 32'h1);
    for (int k = 0; k < 32; k++) begin
      words.push_back($urandom());
      core_push_data = words[k];
      core_push = 1'b1;
      @(negedge core_clk);
    end
    core_push = 1'b0;
    repeat (3) @(negedge core_clk);
    cmp({30'h0, service_request_pin, queue_stop_pin}, 32'h2);
    cmp(core_pop_data, words[0]);
    rd(4'hc, 4'h3);
    cmp(q & 32'h8, 32'h8);
    for (int k = 0; k < 32; k++) begin
      got = 32'h0;
      n = (k == 0) ? 2 : (k == 1) ? 1 : 4;
      for (int b = 0; b < 4; b += n) begin
        be = 4'((1 << n) - 1) << b;
        rd(4'h8, be);
        got = got | (q & lanes(be));
      end
      cmp(got, words[k]);
      if (k == 0) begin
        repeat (3) @(negedge core_clk);
        cmp({31'h0, service_request_pin}, 32'h0);
      end
    end
    repeat (3) @(negedge core_clk);
    cmp({31'h0, queue_stop_pin}, 32'h1);
    mode(16'h0003);
    core_pop = 1'b1;
    @(negedge core_clk);
    core_pop = 1'b0;
    cmp({31'h0, queue_error_pin}, 32'h1);
    rd(4'hc, 4'h3);
    cmp(q & 32'h10, 32'h10);
    m = 16'($urandom());
    wr(4'h8, 4'h3, {16'h0, m});
    wr(4'h8, 4'hc, {~m, 16'h0});
    repeat (3) @(negedge core_clk);
    cmp(core_pop_data, {~m, m});
    conclude();
  end
endmodule
`default_nettype wire
